//--- proc_model.sv
// processor model that services the watchdog input
`timescale 1ns/100ps
`default_nettype none
module proc_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run,
    input wire logic pulse,
    output logic watchdog_kick
);
    int gap = 0;
    initial watchdog_kick = 1'b0;
    always @(posedge clock) begin
        gap <= (run && reset_n && gap < 9) ? gap + 1 : 0;
        if (pulse || (run && reset_n && gap == 9)) begin
            watchdog_kick <= ~watchdog_kick;
        end
    end
endmodule // proc_model
`default_nettype wire

//--- sup_props.sv
// assertion checker for the supply supervisor
`timescale 1ns/100ps
`default_nettype none
module sup_props #(
    parameter RESET_CYCLES = 20,
    parameter WATCHDOG_CYCLES = 40
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic supply_low,
    input wire logic aux_supply_sense_a,
    input wire logic aux_supply_sense_b,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick,
    input wire logic power_fail_sense,
    input wire logic reset_n,
    input wire logic reset,
    input wire logic watchdog_out_n,
    input wire logic power_fail_out_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    int good_cnt;
    int idle_cnt;
    logic kick_q;
    wire logic calm = !supply_low && aux_supply_sense_a && aux_supply_sense_b && manual_reset_n;
    // counters saturate so long runs never wrap
    always @(posedge clock or negedge resetn) begin
        kick_q <= watchdog_kick;
        if (!resetn) begin
            good_cnt <= 0;
            idle_cnt <= 0;
        end else begin
            good_cnt <= calm ? (good_cnt < 99 ? good_cnt + 1 : 99) : 0;
            idle_cnt <= (!reset_n || watchdog_kick != kick_q) ? 0 : (idle_cnt < 999 ? idle_cnt + 1 : 999);
        end
    end
    a_reset_compl: assert property (reset == !reset_n)
        else $error("reset outputs not complementary");
    a_pfo_follow: assert property ($stable(power_fail_sense)[*4] |-> power_fail_out_n == power_fail_sense)
        else $error("power fail output wrong");
    a_supply_hold: assert property (supply_low[*5] |-> !reset_n && !watchdog_out_n)
        else $error("supply low not held");
    a_manual_hold: assert property (!manual_reset_n[*5] |-> !reset_n)
        else $error("manual reset not held");
    a_aux_hold: assert property (!aux_supply_sense_b[*5] |-> !reset_n)
        else $error("aux supply low not held");
    a_stretch_min: assert property ($rose(reset_n) |-> good_cnt >= RESET_CYCLES)
        else $error("reset released early");
    a_release_bound: assert property (good_cnt == RESET_CYCLES + 6 |-> reset_n)
        else $error("reset released late");
    a_wdog_expire: assert property (idle_cnt == WATCHDOG_CYCLES + 5 |-> !watchdog_out_n)
        else $error("watchdog did not expire");
    a_kick_release: assert property ($changed(watchdog_kick) && good_cnt > 8 && reset_n |-> ##[1:4] watchdog_out_n)
        else $error("kick did not clear watchdog");
    cover property ($rose(reset_n));
    cover property ($fell(watchdog_out_n) && calm);
    cover property ($fell(power_fail_out_n));
endmodule // sup_props
bind supervisor_reset_watchdog sup_props #(
    .RESET_CYCLES(RESET_CYCLES),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES)
) u_props (.*);
`default_nettype wire

//--- supervisor_map.vh
// timing constants for the supply supervisor and watchdog
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH

// internal clock period in ns (20 MHz)
`define SUP_CLOCK_NS 50

// reset stretch after the last cause clears, nominal, in ns
`define SUP_RESET_TIMEOUT_NS 200000000
`define SUP_RESET_TIMEOUT_CYC (`SUP_RESET_TIMEOUT_NS / `SUP_CLOCK_NS)

// least stretch still owed after a dip inside a running pulse, in ns
`define SUP_DIP_STRETCH_MIN_NS 140000000
`define SUP_DIP_STRETCH_MIN_CYC \
    ((`SUP_DIP_STRETCH_MIN_NS + `SUP_CLOCK_NS - 1) / `SUP_CLOCK_NS)

// watchdog timeout, nominal, in ns
`define SUP_WATCHDOG_NS 1600000000
`define SUP_WATCHDOG_CYC (`SUP_WATCHDOG_NS / `SUP_CLOCK_NS)

// shortest kick pulse that must be seen, in ns
`define SUP_KICK_PULSE_MIN_NS 50

// counter width, wide enough for the watchdog count
`define SUP_COUNT_W 26

// synchroniser vector bit positions
`define SUP_SYNC_W 6
`define SUP_BIT_SUPPLY_LOW 0
`define SUP_BIT_AUX_A 1
`define SUP_BIT_AUX_B 2
`define SUP_BIT_MANUAL 3
`define SUP_BIT_KICK 4
`define SUP_BIT_POWER_FAIL 5

// synchroniser reset value: supply good, aux good, button up, kick low, no power fail
`define SUP_SYNC_IDLE 6'h2e

`endif

//--- supervisor_reset_watchdog.v
// supply supervisor: stretched processor reset, watchdog and power-fail flag
// Notes on behaviour
// - manual reset low holds reset, then one full timeout after release
// - power-fail output low while comparator reports input below reference
// - kick idle longer than watchdog period expires the watchdog
// - watchdog counter clears on any kick edge and during reset
// - watchdog cannot be disabled; it runs whenever reset is released
// - reset low on main or aux supply low, manual reset, or watchdog variant
// - reset held for the timeout after all causes clear, power-up included
// - watchdog output asserts on timeout and stays until cleared
// - watchdog output also asserts on any supply low or manual reset
// - watchdog output releases on a kick edge with no stretch
// - active-high reset output is the exact complement of reset_n
// - a dip during a running pulse restarts the full stretch
// - watchdog held clear during reset, counts right after release
// - kick pulses of one clock period are seen as edges
// - reset-based variant turns a watchdog timeout into a reset pulse
// - reset waits for all supplies good, then one further timeout
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_map.vh"

module supervisor_reset_watchdog #(
    parameter RESET_CYCLES = `SUP_RESET_TIMEOUT_CYC,
    parameter WATCHDOG_CYCLES = `SUP_WATCHDOG_CYC,
    parameter COUNT_W = `SUP_COUNT_W,
    // 1: triple-monitor variant, aux sense inputs take part
    parameter AUX_MONITOR = 1,
    // 1: reset-based watchdog, no independent watchdog output
    parameter WATCHDOG_RESETS = 0
) (
    input wire clock,
    input wire resetn,
    input wire supply_low,
    input wire aux_supply_sense_a,
    input wire aux_supply_sense_b,
    input wire manual_reset_n,
    input wire watchdog_kick,
    input wire power_fail_sense,
    output wire reset_n,
    output wire reset,
    output wire watchdog_out_n,
    output wire power_fail_out_n
);

    // terminal counts worked out at full width, then cut to the counter on purpose
    localparam [31:0] RESET_LAST_FULL = RESET_CYCLES - 1;
    localparam [31:0] WATCHDOG_LAST_FULL = WATCHDOG_CYCLES - 1;
    localparam [COUNT_W-1:0] RESET_LAST = RESET_LAST_FULL[COUNT_W-1:0];
    localparam [COUNT_W-1:0] WATCHDOG_LAST = WATCHDOG_LAST_FULL[COUNT_W-1:0];
    localparam [COUNT_W-1:0] COUNT_ONE = 1;

    // reset stretch states
    localparam [1:0] ST_HOLD = 2'b00;
    localparam [1:0] ST_STRETCH = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    reg [`SUP_SYNC_W-1:0] sync_a_r;
    reg [`SUP_SYNC_W-1:0] sync_b_r;
    reg kick_last_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [COUNT_W-1:0] rst_cnt_r;
    reg [COUNT_W-1:0] rst_cnt_nxt;
    reg [COUNT_W-1:0] wd_cnt_r;
    reg wd_expired_r;
    reg reset_n_r;
    reg reset_r;
    reg watchdog_out_n_r;
    reg power_fail_out_n_r;

    wire [`SUP_SYNC_W-1:0] raw_in;
    wire supply_low_s;
    wire aux_low_s;
    wire manual_s;
    wire kick_s;
    wire pf_good_s;
    wire kick_edge;
    wire supply_cause;
    wire wd_trip;
    wire in_reset;

    assign raw_in[`SUP_BIT_SUPPLY_LOW] = supply_low;
    assign raw_in[`SUP_BIT_AUX_A] = aux_supply_sense_a;
    assign raw_in[`SUP_BIT_AUX_B] = aux_supply_sense_b;
    assign raw_in[`SUP_BIT_MANUAL] = manual_reset_n;
    assign raw_in[`SUP_BIT_KICK] = watchdog_kick;
    assign raw_in[`SUP_BIT_POWER_FAIL] = power_fail_sense;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // inactive levels: supply good, aux good, button up, kick low
            sync_a_r <= `SUP_SYNC_IDLE;
            sync_b_r <= `SUP_SYNC_IDLE;
        end else begin
            sync_a_r <= raw_in;
            sync_b_r <= sync_a_r;
        end
    end

    assign supply_low_s = sync_b_r[`SUP_BIT_SUPPLY_LOW];
    assign manual_s = ~sync_b_r[`SUP_BIT_MANUAL];
    assign kick_s = sync_b_r[`SUP_BIT_KICK];
    assign pf_good_s = sync_b_r[`SUP_BIT_POWER_FAIL];
    // aux monitors join only in the triple-monitor variant
    assign aux_low_s = (AUX_MONITOR != 0) &
        (~sync_b_r[`SUP_BIT_AUX_A] | ~sync_b_r[`SUP_BIT_AUX_B]);

    // any supply low or manual reset
    assign supply_cause = supply_low_s | aux_low_s | manual_s;

    // timeout becomes a reset cause in the reset-based variant
    assign wd_trip = (WATCHDOG_RESETS != 0) & wd_expired_r;

    // one sample of a one-period pulse is enough for an edge
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            kick_last_r <= 1'b0;
        end else begin
            kick_last_r <= kick_s;
        end
    end
    assign kick_edge = kick_s ^ kick_last_r;

    // reset stretch machine
    always @* begin
        state_nxt = state_r;
        rst_cnt_nxt = rst_cnt_r;
        case (state_r)
            ST_HOLD: begin
                rst_cnt_nxt = {COUNT_W{1'b0}};
                if (!supply_cause) begin
                    state_nxt = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                // a new dip restarts the whole stretch
                if (supply_cause) begin
                    state_nxt = ST_HOLD;
                    rst_cnt_nxt = {COUNT_W{1'b0}};
                end else if (rst_cnt_r >= RESET_LAST) begin
                    state_nxt = ST_RUN;
                    rst_cnt_nxt = {COUNT_W{1'b0}};
                end else begin
                    rst_cnt_nxt = rst_cnt_r + COUNT_ONE;
                end
            end
            ST_RUN: begin
                rst_cnt_nxt = {COUNT_W{1'b0}};
                if (supply_cause) begin
                    state_nxt = ST_HOLD;
                end else if (wd_trip) begin
                    state_nxt = ST_STRETCH;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
                rst_cnt_nxt = {COUNT_W{1'b0}};
            end
        endcase
    end

    // power-up starts in hold so the first release is stretched too
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_HOLD;
            rst_cnt_r <= {COUNT_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    assign in_reset = (state_r != ST_RUN);

    // watchdog counter; no enable, always runs out of reset
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_r <= {COUNT_W{1'b0}};
            wd_expired_r <= 1'b0;
        end else if (in_reset) begin
            wd_cnt_r <= {COUNT_W{1'b0}};
            wd_expired_r <= 1'b0;
        end else if (kick_edge) begin
            wd_cnt_r <= {COUNT_W{1'b0}};
            wd_expired_r <= 1'b0;
        end else if (wd_cnt_r >= WATCHDOG_LAST) begin
            wd_expired_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + COUNT_ONE;
        end
    end

    // registered pin drivers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reset_n_r <= 1'b0;
            reset_r <= 1'b1;
            watchdog_out_n_r <= 1'b0;
            power_fail_out_n_r <= 1'b1;
        end else begin
            reset_n_r <= ~in_reset;
            reset_r <= in_reset;
            // timeout or direct cause, released by a kick
            if (WATCHDOG_RESETS != 0) begin
                watchdog_out_n_r <= 1'b1;
            end else begin
                watchdog_out_n_r <= ~((wd_expired_r & ~kick_edge) | supply_cause);
            end
            power_fail_out_n_r <= pf_good_s;
        end
    end

    assign reset_n = reset_n_r;
    assign reset = reset_r;
    assign watchdog_out_n = watchdog_out_n_r;
    assign power_fail_out_n = power_fail_out_n_r;

endmodule // supervisor_reset_watchdog

`default_nettype wire

//--- supervisor_reset_watchdog_test.sv
// self-checking bench for the supply supervisor
`timescale 1ns/100ps
`default_nettype none
module supervisor_reset_watchdog_test;
    localparam int RC = 20;
    localparam int WC = 40;
    logic clock, resetn, pfs, run, pulse;
    logic [3:0] cause;
    logic [31:0] seed;
    wire logic kick, rst_n, rst, wdo_n, pfo_n;
    int mismatches, checks_done, k;
    supervisor_reset_watchdog #(.RESET_CYCLES(RC), .WATCHDOG_CYCLES(WC)) u_dut (
        .clock(clock), .resetn(resetn), .supply_low(cause[0]),
        .aux_supply_sense_a(!cause[1]), .aux_supply_sense_b(!cause[2]),
        .manual_reset_n(!cause[3]), .watchdog_kick(kick), .power_fail_sense(pfs),
        .reset_n(rst_n), .reset(rst), .watchdog_out_n(wdo_n), .power_fail_out_n(pfo_n));
    proc_model u_proc (.clock(clock), .reset_n(rst_n), .run(run), .pulse(pulse),
        .watchdog_kick(kick));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic seen, input logic exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    // stretch must run its full length after the last cause
    task automatic stretch();
        tick(RC);
        check(rst_n, 1'b0);
        tick(6);
        check(rst_n, 1'b1);
    endtask
    task automatic results();
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #250000;
        mismatches++;
        results();
    end
    initial begin
        // power up with every supply good so the first stretch can finish
        {resetn, cause, pfs, run, pulse} = 8'h00;
        seed = 32'hd52b;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        stretch();
        for (k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            @(posedge clock);
            cause <= 4'h1 << seed[5:4];
            pfs <= seed[6];
            tick(5 + seed[3:0]);
            check(rst_n, 1'b0);
            check(rst, 1'b1);
            check(wdo_n, 1'b0);
            check(pfo_n, seed[6]);
            @(posedge clock);
            cause <= 4'h0;
            if (seed[7]) begin
                tick(10);
                @(posedge clock);
                cause <= 4'h1 << seed[9:8];
                tick(5);
                @(posedge clock);
                cause <= 4'h0;
            end
            stretch();
        end
        @(posedge clock);
        run <= 1'b1;
        tick(3 * WC);
        check(wdo_n, 1'b1);
        @(posedge clock);
        run <= 1'b0;
        tick(WC + 6);
        check(wdo_n, 1'b0);
        tick(WC);
        check(wdo_n, 1'b0);
        check(rst_n, 1'b1);
        @(posedge clock);
        pulse <= 1'b1;
        repeat (2) @(posedge clock);
        pulse <= 1'b0;
        tick(4);
        check(wdo_n, 1'b1);
        results();
    end
endmodule // supervisor_reset_watchdog_test
`default_nettype wire
